// *** inc/cps_pkg.sv ***
package cps_pkg;

    // Width of one converted proximity sample.
    localparam int SAMPLE_W = 12;

    // Filter strengths as right shifts: fast noise filter, slow environment filter.
    localparam int USEFUL_SHIFT = 2;
    localparam int AVG_SHIFT    = 4;

    // Reset values of the processing chain.
    localparam logic [11:0] SAMPLE_RST = 12'h000;
    localparam logic [12:0] DIFF_RST   = 13'h0000;

    // A scan interval of this value switches proximity sensing off.
    localparam logic [2:0] SCAN_OFF = 3'h0;

    // Host configuration, written through the serial port logic on this clock.
    typedef struct packed {
        logic        sensor_pin_select;      // 1: aux sensor pin, 0: screen top layer.
        logic        shield_pin_select;      // 1: aux shield pin, 0: screen bottom layer.
        logic [2:0]  sense_gain_setting;     // Front-end sensitivity.
        logic        sense_gain_boost;       // Extra sensitivity, external sensor only.
        logic [1:0]  frontend_freq_setting;  // Front-end operating frequency.
        logic        high_immunity_enable;   // High noise immunity mode.
        logic [2:0]  scan_interval;          // Wake-up period in scan ticks, 0 is off.
        logic [7:0]  periodic_comp_interval; // Scans between periodic compensations.
        logic [7:0]  stuck_close_timeout;    // Close scans before a stuck compensation.
        logic [11:0] near_threshold;         // Difference above this means close.
        logic [11:0] drift_limit;            // Allowed average drift since compensation.
    } cps_cfg_s;

    // Control word toward the analog front-end and electrode switches.
    typedef struct packed {
        logic        sensor_on_top;    // Sensor role on the screen top layer.
        logic        sensor_on_aux;    // Sensor role on the aux sensor pin.
        logic        shield_on_bottom; // Shield role on the screen bottom layer.
        logic        shield_on_aux;    // Shield role on the aux shield pin.
        logic [2:0]  gain;             // Sensitivity.
        logic        boost;            // Sensitivity boost.
        logic [1:0]  freq;             // Operating frequency.
        logic        high_imm;         // High immunity mode.
        logic        comp_mode;        // Measure environment for compensation.
    } cps_afe_s;

    localparam cps_afe_s AFE_RST = '0;

    // Sequencer states.
    typedef enum logic [2:0] {
        CPS_IDLE, CPS_WAIT_ADC, CPS_COMP, CPS_RAW,
        CPS_USEFUL, CPS_AVG, CPS_DIFF, CPS_STAT
    } cps_state_e;

endpackage

// *** hw/cps_sequencer.sv ***
module cps_sequencer (
    // Clock and reset.
    input  wire logic              core_clk_in,
    input  wire logic              reset_in,
    // Host configuration and requests.
    input  wire cps_pkg::cps_cfg_s cfg_in,
    input  wire logic              host_comp_req_in,
    // Scan timebase and converter sharing.
    input  wire logic              scan_tick_in,
    input  wire logic              touch_busy_in,
    // Analog front-end answer.
    input  wire logic              afe_ready_in,
    input  wire logic [11:0]       afe_sample_in,
    // Analog front-end control.
    output logic                   afe_start_out,
    output cps_pkg::cps_afe_s      afe_ctl_out,
    output logic                   prox_adc_owned_out,
    // Results and status for the host.
    output logic [11:0]            raw_sample_out,
    output logic [11:0]            filtered_sample_out,
    output logic [11:0]            environment_average_out,
    output logic [12:0]            user_difference_out,
    output logic                   near_status_out,
    output logic                   conversion_active_flag_out,
    output logic                   comp_pending_flag_out
);

    // Widens an unsigned sample to a signed 13-bit value.
    function automatic logic signed [12:0] sx(input logic [11:0] v);
        return $signed({1'b0, v});
    endfunction

    cps_pkg::cps_state_e st;          // Sequencer state.
    cps_pkg::cps_state_e next_st;     // Its next value.
    logic [11:0]         raw_sample;  // Last converted sample.
    logic [11:0]         filt;        // Noise-filtered sample.
    logic [11:0]         avg;         // Environment average.
    logic [11:0]         drift_ref;   // Average right after the last compensation.
    logic signed [12:0]  diff;        // User-related difference.
    logic                near;        // Close status.
    logic                pending;     // Merged compensation request.
    logic                first;       // Next scan seeds the filters.
    logic                scan_en_q;   // Scan enable one cycle ago.
    logic [2:0]          scan_cnt;    // Scan ticks counted in idle.
    logic [7:0]          period_cnt;  // Scans since the last periodic request.
    logic [7:0]          stuck_cnt;   // Consecutive close scans.
    logic                conv_q;      // Registered copy of the not-idle state.

    // Decoded conditions.
    wire scan_en    = cfg_in.scan_interval != cps_pkg::SCAN_OFF;
    wire in_idle    = st == cps_pkg::CPS_IDLE;
    wire in_wait    = st == cps_pkg::CPS_WAIT_ADC;
    wire in_comp    = st == cps_pkg::CPS_COMP;
    wire in_stat    = st == cps_pkg::CPS_STAT;
    wire tick_last  = 3'(scan_cnt + 3'h1) == cfg_in.scan_interval;
    wire wake       = in_idle && scan_en && scan_tick_in && tick_last;
    wire adc_take   = in_wait && !touch_busy_in;
    wire comp_done  = in_comp && afe_ready_in;
    wire raw_done   = (st == cps_pkg::CPS_RAW) && afe_ready_in;

    // Filter arithmetic, one step toward the new input each scan.
    wire signed [12:0] useful_step = (sx(raw_sample) - sx(filt)) >>> cps_pkg::USEFUL_SHIFT;
    wire signed [12:0] avg_step    = (sx(filt) - sx(avg)) >>> cps_pkg::AVG_SHIFT;
    wire signed [12:0] useful_sum  = sx(filt) + useful_step;
    wire signed [12:0] avg_sum     = sx(avg) + avg_step;
    wire signed [12:0] next_diff   = sx(filt) - sx(avg);

    // Drift of the average since the last compensation, as a magnitude.
    wire signed [12:0] drift       = sx(avg) - sx(drift_ref);
    wire        [12:0] drift_mag   = drift[12] ? 13'(-drift) : 13'(drift);

    // The five request sources.
    wire req_start  = scan_en && !scan_en_q;
    wire req_drift  = in_stat && (cfg_in.drift_limit != 12'h000)
                      && (drift_mag > {1'b0, cfg_in.drift_limit});
    wire req_period = in_stat && (cfg_in.periodic_comp_interval != 8'h00)
                      && (8'(period_cnt + 8'h01) >= cfg_in.periodic_comp_interval);
    wire req_stuck  = in_stat && near && (cfg_in.stuck_close_timeout != 8'h00)
                      && (8'(stuck_cnt + 8'h01) >= cfg_in.stuck_close_timeout);
    wire req_any    = req_start | host_comp_req_in | req_drift
                      | req_period | req_stuck;

    // A start pulse goes out when the converter is taken and after compensation.
    wire next_start = adc_take | comp_done;

    // Next-state decode of the sequencer.
    always_comb begin
        next_st = st;
        unique case (st)
            cps_pkg::CPS_IDLE:     if (wake) next_st = cps_pkg::CPS_WAIT_ADC;
            cps_pkg::CPS_WAIT_ADC: begin
                // Compensation only ever starts here, at the head of a scan.
                if (adc_take) next_st = pending ? cps_pkg::CPS_COMP
                                                : cps_pkg::CPS_RAW;
            end
            cps_pkg::CPS_COMP:     if (comp_done) next_st = cps_pkg::CPS_RAW;
            cps_pkg::CPS_RAW:      if (raw_done) next_st = cps_pkg::CPS_USEFUL;
            cps_pkg::CPS_USEFUL:   next_st = cps_pkg::CPS_AVG;
            cps_pkg::CPS_AVG:      next_st = cps_pkg::CPS_DIFF;
            cps_pkg::CPS_DIFF:     next_st = cps_pkg::CPS_STAT;
            cps_pkg::CPS_STAT:     next_st = cps_pkg::CPS_IDLE;
        endcase
    end

    // Electrode routing and front-end settings, applied only while sampling.
    // Outside an operation every electrode switch is open so touch owns the pins.
    wire     next_owned = (next_st == cps_pkg::CPS_COMP) || (next_st == cps_pkg::CPS_RAW);
    cps_pkg::cps_afe_s next_afe;
    always_comb begin
        next_afe = cps_pkg::AFE_RST;
        if (next_owned) begin
            next_afe.sensor_on_aux    = cfg_in.sensor_pin_select;
            next_afe.sensor_on_top    = !cfg_in.sensor_pin_select;
            next_afe.shield_on_aux    = cfg_in.shield_pin_select;
            next_afe.shield_on_bottom = !cfg_in.shield_pin_select;
            next_afe.gain             = cfg_in.sense_gain_setting;
            next_afe.boost            = cfg_in.sense_gain_boost;
            next_afe.freq             = cfg_in.frontend_freq_setting;
            next_afe.high_imm         = cfg_in.high_immunity_enable;
            next_afe.comp_mode        = next_st == cps_pkg::CPS_COMP;
        end
    end

    // State, converter ownership and front-end control registers.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            st                 <= cps_pkg::CPS_IDLE;
            afe_start_out      <= 1'b0;
            afe_ctl_out        <= cps_pkg::AFE_RST;
            prox_adc_owned_out <= 1'b0;
            scan_en_q          <= 1'b0;
            conv_q             <= 1'b0;
        end else begin
            st                 <= next_st;
            afe_start_out      <= next_start;
            afe_ctl_out        <= next_afe;
            prox_adc_owned_out <= next_owned;
            scan_en_q          <= scan_en;
            // Loaded from the next state so it tracks the state register exactly.
            conv_q             <= next_st != cps_pkg::CPS_IDLE;
        end
    end

    // Scan tick counter; ticks that land during an operation are dropped.
    always_ff @(posedge core_clk_in) begin
        if (reset_in || !scan_en) begin
            scan_cnt <= 3'h0;
        end else if (in_idle && scan_tick_in) begin
            scan_cnt <= tick_last ? 3'h0 : 3'(scan_cnt + 3'h1);
        end
    end

    // Merged pending flag; a new request wins over the clear of the same cycle.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            pending <= 1'b0;
        end else begin
            pending <= req_any | (pending & !comp_done);
        end
    end

    // Processing chain, one stage per state.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            raw_sample <= cps_pkg::SAMPLE_RST;
            filt       <= cps_pkg::SAMPLE_RST;
            avg        <= cps_pkg::SAMPLE_RST;
            drift_ref  <= cps_pkg::SAMPLE_RST;
            diff       <= cps_pkg::DIFF_RST;
            near       <= 1'b0;
            first      <= 1'b1;
        end else begin
            if (comp_done) begin
                // New offset: filters restart from the next sample.
                first <= 1'b1;
            end
            if (raw_done) begin
                raw_sample <= afe_sample_in;
            end
            if (st == cps_pkg::CPS_USEFUL) begin
                filt <= first ? raw_sample : useful_sum[11:0];
            end
            if (st == cps_pkg::CPS_AVG) begin
                first <= 1'b0;
                if (first) begin
                    avg       <= filt;
                    drift_ref <= filt;
                end else if (!near) begin
                    avg <= avg_sum[11:0];
                end
            end
            if (st == cps_pkg::CPS_DIFF) begin
                diff <= next_diff;
            end
            if (in_stat) begin
                // Only this state moves the status, so it holds between scans.
                near <= diff > sx(cfg_in.near_threshold);
            end
        end
    end

    // Scan-based request counters, advanced once per finished scan.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            period_cnt <= 8'h00;
            stuck_cnt  <= 8'h00;
        end else if (in_stat) begin
            period_cnt <= req_period ? 8'h00 : 8'(period_cnt + 8'h01);
            stuck_cnt  <= (!near || req_stuck) ? 8'h00 : 8'(stuck_cnt + 8'h01);
        end
    end

    // Host-visible copies come straight from the working registers.
    assign raw_sample_out             = raw_sample;
    assign filtered_sample_out        = filt;
    assign environment_average_out    = avg;
    assign user_difference_out        = diff;
    assign near_status_out            = near;
    assign conversion_active_flag_out = conv_q;
    assign comp_pending_flag_out      = pending;

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);

    // Fixed processing order after the sample arrives.
    sequence chain_s;
        st == cps_pkg::CPS_USEFUL ##1 st == cps_pkg::CPS_AVG ##1
        st == cps_pkg::CPS_DIFF ##1 st == cps_pkg::CPS_STAT ##1 in_idle;
    endsequence

    chain_order_a: assert property (raw_done |=> chain_s)
        else $error("Processing chain left its fixed order.");

    pend_hold_a: assert property (pending && !in_comp |=> pending)
        else $error("Compensation flag dropped before compensation.");

    start_req_a: assert property (req_start |=> comp_pending_flag_out)
        else $error("Enabling scans did not request compensation.");

    host_req_a: assert property (host_comp_req_in |=> comp_pending_flag_out)
        else $error("Host compensation request was lost.");

    comp_start_a: assert property ($rose(in_comp) |-> $past(in_wait) && $past(pending))
        else $error("Compensation started outside a scan start.");

    comp_first_a: assert property (adc_take && pending |=> in_comp ##0 afe_start_out)
        else $error("Pending compensation not run before sample.");

    adc_share_a: assert property ($rose(prox_adc_owned_out) |-> !$past(touch_busy_in))
        else $error("Converter taken while touch was using it.");

    scan_off_a: assert property (!scan_en && in_idle |=> in_idle)
        else $error("Operation started with scans disabled.");

    avg_freeze_a: assert property (near && !first && st == cps_pkg::CPS_AVG |=> $stable(avg))
        else $error("Average moved while status was close.");

    stat_cmp_a: assert property (in_stat |=>
        near == ($past(diff) > sx($past(cfg_in.near_threshold))))
        else $error("Status does not match threshold compare.");

    stat_keep_a: assert property (!in_stat |=> $stable(near_status_out))
        else $error("Status changed between scans.");

endmodule // cps_sequencer

// *** tb/cps_afe_model.sv ***
// Behavioural front-end and electrode: answers each start after a chosen latency.
module cps_afe_model (
    // Clock and reset.
    input  wire logic              clk_in,
    input  wire logic              reset_in,
    // Control from the sequencer.
    input  wire logic              start_in,
    input  wire cps_pkg::cps_afe_s ctl_in,
    // Capacitance level and latency chosen by the bench.
    input  wire logic [11:0]       level_in,
    input  wire logic [3:0]        delay_in,
    // Answer toward the sequencer.
    output logic                   ready_out,
    output logic [11:0]            sample_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [4:0] wait_cnt; // Cycles left in the job, zero when idle.
    logic       comp_run; // The job in flight measures the environment.

    initial ready_out = 1'b0;

    // Data toggles outside the ready pulse, so a late capture cannot pass by luck.
    always @(posedge clk_in) begin
        ready_out <= 1'b0;
        sample_out <= ~sample_out;
        if (reset_in) begin
            wait_cnt <= 5'h00;
            sample_out <= 12'h5a5;
        end else if (start_in) begin
            wait_cnt <= {1'b0, delay_in} + 5'h01;
            comp_run <= ctl_in.comp_mode;
        end else if (wait_cnt == 5'h01) begin
            // A compensation answer carries no sample worth keeping.
            ready_out <= 1'b1;
            sample_out <= comp_run ? ~level_in : level_in;
            wait_cnt <= 5'h00;
        end else if (wait_cnt != 5'h00) begin
            wait_cnt <= wait_cnt - 5'h01;
        end
    end
endmodule // cps_afe_model

// *** tb/tb.sv ***
// Self-checking bench for the proximity sequencer with an integer reference model.
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk_in = 1'b0, reset_in = 1'b1, host_req = 1'b0, tick = 1'b0, busy = 1'b0;
    cps_pkg::cps_cfg_s cfg = '0;      // Host configuration.
    logic [11:0] level = 12'h700;    // Sensor level handed to the front-end.
    logic [3:0]  delay = 4'h2;        // Front-end latency.
    logic ready, start, owned, near, conv, pend;
    logic [11:0] smp, raw, filt, avg;
    logic [12:0] diff;
    cps_pkg::cps_afe_s ctl, last_ctl;
    int err_total = 0, samples_checked = 0, comp_seen = 0, comp_exp = 0;
    int mf, ma, md, mnear = 0;        // Reference filter, average, difference, status.
    logic [31:0] xs = 32'd92265;      // Random state.

    always #10 core_clk_in = ~core_clk_in;

    cps_sequencer cps_sequencer_inst (.core_clk_in(core_clk_in), .reset_in(reset_in),
        .cfg_in(cfg), .host_comp_req_in(host_req), .scan_tick_in(tick),
        .touch_busy_in(busy), .afe_ready_in(ready), .afe_sample_in(smp),
        .afe_start_out(start), .afe_ctl_out(ctl), .prox_adc_owned_out(owned),
        .raw_sample_out(raw), .filtered_sample_out(filt), .environment_average_out(avg),
        .user_difference_out(diff), .near_status_out(near),
        .conversion_active_flag_out(conv), .comp_pending_flag_out(pend));

    cps_afe_model cps_afe_model_inst (.clk_in(core_clk_in), .reset_in(reset_in),
        .start_in(start), .ctl_in(ctl), .level_in(level), .delay_in(delay),
        .ready_out(ready), .sample_out(smp));

    // Records the settings of each start and counts compensation starts.
    always @(posedge core_clk_in) begin
        if (start === 1'b1) begin
            last_ctl <= ctl;
            if (ctl.comp_mode === 1'b1) comp_seen++;
        end
    end

    function automatic logic [31:0] rnd();
        xs = xs ^ (xs << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
        return xs;
    endfunction

    task automatic check(input string name, input logic [12:0] seen, input logic [12:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic wait_conv(input logic val);
        int k;
        k = 0;
        while (conv !== val && k < 200) begin
            @(posedge core_clk_in);
            #1;
            k++;
        end
        check("conv_flag", {12'h000, conv}, {12'h000, val});
    endtask

    // One wake-up: ticks, optional converter contention, then a full compare.
    task automatic do_scan(input bit comp);
        logic [11:0] s;
        bit hold;
        s = 12'h700 + 12'(rnd() % 256);
        hold = rnd() % 2;
        @(posedge core_clk_in) level <= s;
        delay <= 4'(rnd());
        busy <= hold;
        repeat (cfg.scan_interval) begin
            @(posedge core_clk_in) tick <= 1'b1;
            @(posedge core_clk_in) tick <= 1'b0;
        end
        #1;
        wait_conv(1'b1);
        check("pending_run", {12'h000, pend}, {12'h000, comp});
        if (hold) begin
            repeat (3) @(posedge core_clk_in);
            #1;
            check("owned_busy", {12'h000, owned}, 13'h0000);
            @(posedge core_clk_in) busy <= 1'b0;
        end
        wait_conv(1'b0);
        // Reference model: seed after compensation, else filter, freeze while close.
        if (comp) begin
            mf = s;
            ma = mf;
        end else begin
            mf = mf + ((int'(s) - mf) >>> cps_pkg::USEFUL_SHIFT);
            if (mnear == 0) ma = ma + ((mf - ma) >>> cps_pkg::AVG_SHIFT);
        end
        md = mf - ma;
        mnear = (md > int'(cfg.near_threshold)) ? 1 : 0;
        comp_exp += comp;
        check("raw", {1'b0, raw}, {1'b0, s});
        check("filtered", {1'b0, filt}, 13'(mf));
        check("average", {1'b0, avg}, 13'(ma));
        check("difference", diff, 13'(md));
        check("near", {12'h000, near}, 13'(mnear));
        check("pending_done", {12'h000, pend}, 13'h0000);
        check("comp_count", 13'(comp_seen), 13'(comp_exp));
        check("ctl_route", {1'b0, last_ctl}, {1'b0, ~cfg.sensor_pin_select,
            cfg.sensor_pin_select, ~cfg.shield_pin_select, cfg.shield_pin_select,
            cfg.sense_gain_setting, cfg.sense_gain_boost, cfg.frontend_freq_setting,
            cfg.high_immunity_enable, 1'b0});
        check("ctl_idle", {1'b0, ctl}, 13'h0000);
    endtask

    initial begin
        #200000;
        err_total++;
        print_verdict();
    end

    // Main sequence.
    initial begin
        repeat (4) @(posedge core_clk_in);
        reset_in <= 1'b0;
        cfg.near_threshold <= 12'h010;
        repeat (3) begin
            @(posedge core_clk_in) tick <= 1'b1;
            @(posedge core_clk_in) tick <= 1'b0;
        end
        #1;
        check("off_conv", {12'h000, conv}, 13'h0000);
        check("off_pend", {12'h000, pend}, 13'h0000);
        @(posedge core_clk_in) cfg.scan_interval <= 3'h1;
        repeat (2) @(posedge core_clk_in);
        #1;
        check("startup_req", {12'h000, pend}, 13'h0001);
        do_scan(1'b1);
        // Two host requests while idle must merge and wait for the next scan.
        @(posedge core_clk_in) host_req <= 1'b1;
        @(posedge core_clk_in) host_req <= 1'b0;
        repeat (3) @(posedge core_clk_in);
        host_req <= 1'b1;
        @(posedge core_clk_in) host_req <= 1'b0;
        repeat (5) @(posedge core_clk_in);
        #1;
        check("host_req", {12'h000, pend}, 13'h0001);
        check("no_early_comp", 13'(comp_seen), 13'(comp_exp));
        do_scan(1'b1);
        for (int i = 0; i < 16; i++) begin
            // Gain kept low, boost only with the aux sensor.
            @(posedge core_clk_in) cfg.sensor_pin_select <= rnd() % 2;
            cfg.shield_pin_select <= rnd() % 2;
            cfg.sense_gain_setting <= 3'(rnd() % 2);
            cfg.frontend_freq_setting <= 2'(rnd());
            cfg.high_immunity_enable <= rnd() % 2;
            cfg.near_threshold <= 12'(rnd() % 64);
            cfg.scan_interval <= 3'(1 + rnd() % 3);
            @(posedge core_clk_in) cfg.sense_gain_boost <= cfg.sensor_pin_select & rnd() % 2;
            do_scan(1'b0);
        end
        // Periodic source: one finished scan leaves a request for the next.
        @(posedge core_clk_in) cfg.periodic_comp_interval <= 8'h01;
        repeat (cfg.scan_interval) begin
            @(posedge core_clk_in) tick <= 1'b1;
            @(posedge core_clk_in) tick <= 1'b0;
        end
        #1;
        wait_conv(1'b1);
        wait_conv(1'b0);
        check("period_req", {12'h000, pend}, 13'h0001);
        @(posedge core_clk_in) cfg.periodic_comp_interval <= 8'h00;
        do_scan(1'b1);
        print_verdict();
    end
endmodule // tb
